/* hdl/ebt_pkg.sv */
package ebt_pkg;

	// Trace memory geometry
	localparam int TRACE_DEPTH   = 2048;
	localparam int TRACE_AW      = 11;
	localparam int PA_W          = 16;
	localparam int PD_W          = 8;
	localparam int MA_W          = 12;
	localparam int MD_W          = 8;
	localparam int PORT_W        = 4;
	localparam int PROBE_W       = 8;

	// APB register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_SELECT   = 8'h04;
	localparam logic [7:0] OFS_DELAY    = 8'h08;
	localparam logic [7:0] OFS_TMODE    = 8'h0c;
	localparam logic [7:0] OFS_CMD      = 8'h10;
	localparam logic [7:0] OFS_STATUS   = 8'h14;
	localparam logic [7:0] OFS_TRIG     = 8'h18;
	localparam logic [7:0] OFS_RDPTR    = 8'h1c;
	localparam logic [7:0] OFS_RDDATA   = 8'h20;
	localparam logic [7:0] OFS_SECTION  = 8'h24;
	localparam logic [7:0] OFS_COND0    = 8'h40;

	// Event select bits: 0..3 data access conditions, 4..5 program address conditions
	localparam int          NUM_COND    = 6;
	localparam logic [5:0]  SELECT_RST  = 6'h30;

	// Command register bits (write one to act)
	localparam int CMD_RUN       = 0;
	localparam int CMD_HALT      = 1;
	localparam int CMD_RESET     = 2;
	localparam int CMD_STEP      = 3;
	localparam int CMD_STEP_OVER = 4;
	localparam int CMD_ESCAPE    = 5;

	// Execution modes
	typedef enum logic [1:0]
	{
		EXEC_FREE  = 2'b00,
		EXEC_BREAK = 2'b01,
		EXEC_STEP  = 2'b10
	} ebt_exec_e;

	// Trace qualification modes
	typedef enum logic [1:0]
	{
		TRC_ALL     = 2'b00,
		TRC_QUAL    = 2'b01,
		TRC_SECTION = 2'b10
	} ebt_trc_e;

	// Unit state
	typedef enum logic [2:0]
	{
		ST_IDLE     = 3'b000,
		ST_RUN      = 3'b001,
		ST_STEPWAIT = 3'b010,
		ST_STEPRUN  = 3'b011,
		ST_OVER     = 3'b100
	} ebt_state_e;

	// One executed cycle as seen from the core
	typedef struct packed
	{
		logic [PA_W-1:0]    pa;
		logic [PD_W-1:0]    pd;
		logic [MA_W-1:0]    ma;
		logic [MD_W-1:0]    md;
		logic               mrd;
		logic               mwr;
		logic [PORT_W-1:0]  port;
		logic [PROBE_W-1:0] probe;
	} ebt_frame_s;

	localparam int FRAME_W = $bits(ebt_frame_s);

	// Condition register: address to match, kind bits (bit16 read, bit17 write)
	typedef struct packed
	{
		logic        on_wr;
		logic        on_rd;
		logic [15:0] addr;
	} ebt_cond_s;

endpackage

/* hdl/ebt_unit.sv */
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module ebt_unit
	import ebt_pkg::*;
#(
	parameter int DEPTH = TRACE_DEPTH
)
(
	input  wire logic              sys_clk,
	input  wire logic              srst,
	input  wire logic [7:0]        paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              core_cycle_valid,
	input  wire ebt_frame_s        core_frame,
	input  wire logic              core_call_taken,
	input  wire logic              core_return_taken,
	input  wire logic              core_invalid_access,
	output logic                   core_run,
	output logic                   core_reset,
	output logic                   core_in_step
);

	localparam int AW = $clog2(DEPTH);

	if (DEPTH != TRACE_DEPTH)
		$error("ebt_unit: trace depth must be 2048 frames");

	////////////////////////////////////////////////////////////////////////////
	// Condition matching, shared by break, qualified and sectional trace

	function automatic logic cond_hit(input ebt_cond_s c, input int idx, input ebt_frame_s f);
		logic hit;
		hit = 1'b0;
		if (idx < 4)
			hit = ((c.on_rd && f.mrd) || (c.on_wr && f.mwr)) && (f.ma == c.addr[MA_W-1:0]);
		else
			hit = (f.pa == c.addr);
		return hit;
	endfunction

	function automatic logic any_hit(input logic [5:0] sel, input ebt_cond_s c [NUM_COND],
		input ebt_frame_s f);
		logic h;
		h = 1'b0;
		for (int i = 0; i < NUM_COND; i++)
			if (sel[i] && cond_hit(c[i], i, f))
				h = 1'b1;
		return h;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	ebt_state_e           state, next_state;
	ebt_exec_e            exec_mode, next_exec_mode;
	ebt_trc_e             trc_mode, next_trc_mode;
	ebt_cond_s            cond [NUM_COND];
	ebt_cond_s            next_cond [NUM_COND];
	logic [5:0]           sel_brk, next_sel_brk;
	logic [5:0]           sel_en, next_sel_en;
	logic [5:0]           sel_dis, next_sel_dis;
	logic [AW-1:0]        delay, next_delay;
	logic                 centered, next_centered;
	logic                 tracing, next_tracing;
	logic                 in_section, next_in_section;
	logic                 triggered, next_triggered;
	logic [AW:0]          dcount, next_dcount;
	logic [AW-1:0]        wptr, next_wptr;
	logic [AW-1:0]        trig_idx, next_trig_idx;
	logic [AW-1:0]        rptr, next_rptr;
	logic                 wrapped, next_wrapped;
	logic [2:0]           stop_cause, next_stop_cause;
	logic [FRAME_W-1:0]   mem [DEPTH];
	logic [31:0]          next_prdata;
	logic                 next_pready;
	logic                 next_pslverr;
	logic                 next_core_run;
	logic                 next_core_reset;
	logic                 next_core_in_step;

	logic                 wr_acc;
	logic                 rd_acc;
	logic                 cmd_wr;
	logic [5:0]           cmd;
	logic                 hit_brk;
	logic                 rec;
	logic                 forced;
	logic                 step_clear;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus, commands, breaks and tracer

	always_comb
	begin
		next_state        = state;
		next_exec_mode    = exec_mode;
		next_trc_mode     = trc_mode;
		next_cond         = cond;
		next_sel_brk      = sel_brk;
		next_sel_en       = sel_en;
		next_sel_dis      = sel_dis;
		next_delay        = delay;
		next_centered     = centered;
		next_tracing      = tracing;
		next_in_section   = in_section;
		next_triggered    = triggered;
		next_dcount       = dcount;
		next_wptr         = wptr;
		next_trig_idx     = trig_idx;
		next_rptr         = rptr;
		next_wrapped      = wrapped;
		next_stop_cause   = stop_cause;
		next_core_reset   = 1'b0;
		next_prdata       = 32'h0;
		next_pslverr      = 1'b0;
		step_clear        = 1'b0;
		rec               = 1'b0;

		// One-wait APB: access phase answered in its second cycle, pready registered
		wr_acc      = psel && penable && !pready && pwrite;
		rd_acc      = psel && penable && !pready && !pwrite;
		next_pready = psel && penable && !pready;
		cmd_wr      = wr_acc && (paddr == OFS_CMD);
		cmd         = cmd_wr ? pwdata[5:0] : 6'h0;

		// Configuration writes only take while stopped, so live matching stays coherent
		if (wr_acc && state == ST_IDLE)
		begin
			case (paddr)
				OFS_CTRL:    next_exec_mode = ebt_exec_e'(pwdata[1:0]);
				OFS_SELECT:  next_sel_brk = pwdata[5:0];
				OFS_DELAY:
				begin
					next_delay    = pwdata[AW-1:0];
					next_centered = pwdata[16];
				end
				OFS_TMODE:   next_trc_mode = ebt_trc_e'(pwdata[1:0]);
				OFS_SECTION:
				begin
					next_sel_en  = pwdata[5:0];
					next_sel_dis = pwdata[13:8];
				end
				OFS_RDPTR:   next_rptr = pwdata[AW-1:0];
				default:
				begin
					if (paddr >= OFS_COND0 && paddr < OFS_COND0 + 8'h18 && paddr[1:0] == 2'b00)
						next_cond[3'((paddr - OFS_COND0) >> 2)] = pwdata[17:0];
				end
			endcase
		end
		else if (wr_acc && paddr == OFS_RDPTR)
			next_rptr = pwdata[AW-1:0];

		// Register reads; unmapped offsets return error
		if (rd_acc)
		begin
			case (paddr)
				OFS_CTRL:    next_prdata = {30'h0, exec_mode};
				OFS_SELECT:  next_prdata = {26'h0, sel_brk};
				OFS_DELAY:   next_prdata = {15'h0, centered, 5'h0, delay};
				OFS_TMODE:   next_prdata = {30'h0, trc_mode};
				OFS_CMD:     next_prdata = 32'h0;
				OFS_STATUS:  next_prdata = {21'h0, stop_cause, triggered, tracing, wrapped,
					2'h0, state};
				OFS_TRIG:    next_prdata = {21'h0, trig_idx};
				OFS_RDPTR:   next_prdata = {21'h0, rptr};
				OFS_RDDATA:  next_prdata = 32'(mem[rptr]);
				OFS_SECTION: next_prdata = {18'h0, sel_dis, 2'h0, sel_en};
				default:
				begin
					if (paddr >= OFS_COND0 && paddr < OFS_COND0 + 8'h18 && paddr[1:0] == 2'b00)
						next_prdata = {14'h0, cond[3'((paddr - OFS_COND0) >> 2)]};
					else
						next_pslverr = 1'b1;
				end
			endcase
		end

		// Break sources
		hit_brk = core_cycle_valid && any_hit(sel_brk, cond, core_frame);
		forced  = 1'b0;

		case (state)
			ST_IDLE:
			begin
				if (cmd[CMD_RESET])
				begin
					next_core_reset = 1'b1;
					next_stop_cause = 3'h2;
				end
				else if (cmd[CMD_RUN])
				begin
					next_state      = (exec_mode == EXEC_STEP) ? ST_STEPWAIT : ST_RUN;
					next_tracing    = 1'b1;
					next_triggered  = 1'b0;
					next_wptr       = '0;
					next_wrapped    = 1'b0;
					next_in_section = 1'b0;
					next_stop_cause = 3'h0;
					next_dcount     = centered ? (AW+1)'(DEPTH/2) : {1'b0, delay};
				end
			end
			ST_RUN, ST_OVER:
			begin
				// Forced stops win over any pending event break
				if (core_invalid_access)
				begin
					forced = 1'b1;
					next_stop_cause = 3'h3;
				end
				else if (cmd[CMD_RESET])
				begin
					forced = 1'b1;
					next_core_reset = 1'b1;
					next_stop_cause = 3'h2;
				end
				else if (cmd[CMD_HALT])
				begin
					forced = 1'b1;
					next_stop_cause = 3'h1;
				end
				if (forced)
				begin
					next_state   = ST_IDLE;
					next_tracing = 1'b0;
				end
				else if (state == ST_OVER)
				begin
					if (core_cycle_valid && core_return_taken)
						next_state = ST_STEPWAIT;
				end
				else if (core_cycle_valid && tracing)
				begin
					// Record according to trace qualification
					case (trc_mode)
						TRC_QUAL:    rec = any_hit(6'h3f, cond, core_frame);
						TRC_SECTION:
						begin
							if (any_hit(sel_en, cond, core_frame))
								next_in_section = 1'b1;
							if (in_section && any_hit(sel_dis, cond, core_frame))
								next_in_section = 1'b0;
							rec = in_section || any_hit(sel_en, cond, core_frame);
						end
						default:     rec = 1'b1;
					endcase
					// Trigger capture
					if (hit_brk && !triggered)
					begin
						next_triggered = 1'b1;
						next_trig_idx  = wptr;
					end
					if ((triggered || hit_brk) && rec)
					begin
						if (dcount == '0)
						begin
							next_tracing = 1'b0;
							if (exec_mode == EXEC_BREAK)
							begin
								next_state      = ST_STEPWAIT;
								next_stop_cause = 3'h4;
							end
						end
						else
							next_dcount = dcount - 1'b1;
					end
				end
			end
			ST_STEPWAIT:
			begin
				if (core_invalid_access || cmd[CMD_RESET] || cmd[CMD_ESCAPE])
				begin
					next_state      = ST_IDLE;
					next_core_reset = cmd[CMD_RESET];
					next_stop_cause = core_invalid_access ? 3'h3 : 3'h1;
				end
				else if (cmd[CMD_STEP_OVER] && core_call_taken)
					next_state = ST_OVER;
				else if (cmd[CMD_STEP])
				begin
					next_state   = ST_STEPRUN;
					step_clear   = 1'b1;
					next_wptr    = '0;
					next_wrapped = 1'b0;
				end
			end
			ST_STEPRUN:
			begin
				if (core_invalid_access)
				begin
					next_state      = ST_IDLE;
					next_stop_cause = 3'h3;
				end
				else if (core_cycle_valid)
				begin
					rec           = 1'b1;
					next_state    = ST_STEPWAIT;
					next_trig_idx = wptr;
				end
			end
			default: next_state = ST_IDLE;
		endcase

		// Circular write pointer
		if (rec)
		begin
			next_wptr = wptr + 1'b1;
			if (wptr == AW'(DEPTH-1))
				next_wrapped = 1'b1;
		end

		// Read pointer lands on trigger, or oldest frame, on stop
		if (state != ST_IDLE && next_state == ST_IDLE || (tracing && !next_tracing))
			next_rptr = (next_triggered || state == ST_STEPRUN) ? next_trig_idx
				: (next_wrapped ? next_wptr : '0);

		next_core_run     = (next_state == ST_RUN) || (next_state == ST_OVER) ||
			(next_state == ST_STEPRUN);
		next_core_in_step = (next_state == ST_STEPWAIT) || (next_state == ST_STEPRUN);
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state        <= ST_IDLE;
			exec_mode    <= EXEC_FREE;
			trc_mode     <= TRC_ALL;
			for (int i = 0; i < NUM_COND; i++)
				cond[i] <= '0;
			sel_brk      <= SELECT_RST;
			sel_en       <= 6'h0;
			sel_dis      <= 6'h0;
			delay        <= '0;
			centered     <= 1'b0;
			tracing      <= 1'b0;
			in_section   <= 1'b0;
			triggered    <= 1'b0;
			dcount       <= '0;
			wptr         <= '0;
			trig_idx     <= '0;
			rptr         <= '0;
			wrapped      <= 1'b0;
			stop_cause   <= 3'h0;
			prdata       <= 32'h0;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			core_run     <= 1'b0;
			core_reset   <= 1'b0;
			core_in_step <= 1'b0;
		end
		else
		begin
			state        <= next_state;
			exec_mode    <= next_exec_mode;
			trc_mode     <= next_trc_mode;
			cond         <= next_cond;
			sel_brk      <= next_sel_brk;
			sel_en       <= next_sel_en;
			sel_dis      <= next_sel_dis;
			delay        <= next_delay;
			centered     <= next_centered;
			tracing      <= next_tracing;
			in_section   <= next_in_section;
			triggered    <= next_triggered;
			dcount       <= next_dcount;
			wptr         <= next_wptr;
			trig_idx     <= next_trig_idx;
			rptr         <= next_rptr;
			wrapped      <= next_wrapped;
			stop_cause   <= next_stop_cause;
			prdata       <= next_prdata;
			pready       <= next_pready;
			pslverr      <= next_pslverr;
			core_run     <= next_core_run;
			core_reset   <= next_core_reset;
			core_in_step <= next_core_in_step;
		end
	end

	// Trace storage; a step clears only logically by pointer reset, which keeps it flop-cheap
	always_ff @(posedge sys_clk)
	begin
		if (rec)
			mem[wptr] <= core_frame;
	end

endmodule // ebt_unit

`default_nettype wire

/* tb/ebt_unit_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module ebt_unit_assertions
	import ebt_pkg::*;
#(
	parameter int DEPTH = TRACE_DEPTH
)
(
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        core_cycle_valid,
	input wire ebt_frame_s  core_frame,
	input wire logic        core_call_taken,
	input wire logic        core_return_taken,
	input wire logic        core_invalid_access,
	input wire logic        core_run,
	input wire logic        core_reset,
	input wire logic        core_in_step
);
	// Command write taken at this edge: the unit acts in the access cycle before pready,
	// so a later edge would already see the core stopped and prove nothing
	wire logic cmd_wr = psel && penable && !pready && pwrite && paddr == OFS_CMD;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////////////
	property p_ready_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait");
	property p_err_ready;
		pslverr |-> pready && psel && penable;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr outside answer");
	property p_out_reset;
		$fell(srst) |-> !core_run && !core_reset && !core_in_step;
	endproperty
	a_out_reset: assert property (p_out_reset) else $error("outputs not idle after reset");
	// Halt is only honoured in real-time runs, so step mode is excluded
	property p_halt_stop;
		cmd_wr && pwdata[CMD_HALT] && core_run && !core_in_step |-> ##[1:2] !core_run;
	endproperty
	a_halt_stop: assert property (p_halt_stop) else $error("halt did not stop core");
	property p_reset_pulse;
		core_reset |=> !core_reset;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("core reset too long");
	property p_reset_stop;
		cmd_wr && pwdata[CMD_RESET] && core_run && !core_in_step |-> ##[1:2] core_reset && !core_run;
	endproperty
	a_reset_stop: assert property (p_reset_stop) else $error("reset halt missing");
	property p_bad_stop;
		core_run && core_invalid_access |-> ##[1:2] !core_run;
	endproperty
	a_bad_stop: assert property (p_bad_stop) else $error("invalid access kept running");
	property p_step_one;
		core_in_step && !core_call_taken && $rose(core_run) |=> !core_run;
	endproperty
	a_step_one: assert property (p_step_one) else $error("step ran past one cycle");
	property p_step_entry;
		$rose(core_in_step) |-> ##[0:1] !core_run;
	endproperty
	a_step_entry: assert property (p_step_entry) else $error("single step with core running");
	c_step: cover property (core_in_step && core_run);
	c_reset: cover property (core_reset);
	c_err: cover property (pslverr);
endmodule // ebt_unit_assertions

bind ebt_unit ebt_unit_assertions #(.DEPTH(DEPTH)) u_chk
(
	.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.core_cycle_valid(core_cycle_valid), .core_frame(core_frame),
	.core_call_taken(core_call_taken), .core_return_taken(core_return_taken),
	.core_invalid_access(core_invalid_access), .core_run(core_run),
	.core_reset(core_reset), .core_in_step(core_in_step)
);
`default_nettype wire

/* tb/ebt_core_model.sv */
`timescale 1ns/100ps
`default_nettype none

module ebt_core_model
	import ebt_pkg::*;
(
	input  wire logic  sys_clk,
	input  wire logic  srst,
	input  wire logic  core_run,
	input  wire logic  core_reset,
	input  wire logic  bad,
	output logic       core_cycle_valid,
	output ebt_frame_s core_frame,
	output logic       core_call_taken,
	output logic       core_return_taken,
	output logic       core_invalid_access,
	output logic [15:0] pa
);
	logic [15:0] next_pa;
	// Program counter: cleared by core reset, one step per executed cycle
	always_comb
	begin
		next_pa = pa;
		if (srst || core_reset)
			next_pa = 16'h0000;
		else if (core_run)
			next_pa = pa + 16'h0001;
	end
	always_ff @(posedge sys_clk)
		pa <= next_pa;
	// Fields follow the counter so the bench can predict them; a stopped core
	// shows inverted data rather than a stale frame
	always_comb
	begin
		core_frame = {pa, pa[7:0], pa[13:2], ~pa[7:0], 2'b10, pa[3:0], pa[7:0]};
		if (!core_run)
			core_frame = ~core_frame;
		core_cycle_valid = core_run;
		core_invalid_access = core_run & bad;
		core_call_taken = 1'b0; // No calls, so step-over stays unexercised
		core_return_taken = 1'b0;
	end
endmodule // ebt_core_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top
	import ebt_pkg::*;
;
	logic        sys_clk, srst, psel, penable, pwrite, bad, rerr;
	logic        pready, pslverr, core_run, core_reset, core_in_step;
	logic        core_cycle_valid, core_call_taken, core_return_taken, core_invalid_access;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] pa, base;
	ebt_frame_s  core_frame;
	int          n_mismatch = 0;
	int          check_count = 0;

	ebt_unit dut
	(
		.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_cycle_valid(core_cycle_valid), .core_frame(core_frame),
		.core_call_taken(core_call_taken), .core_return_taken(core_return_taken),
		.core_invalid_access(core_invalid_access), .core_run(core_run),
		.core_reset(core_reset), .core_in_step(core_in_step)
	);
	ebt_core_model core
	(
		.sys_clk(sys_clk), .srst(srst), .core_run(core_run), .core_reset(core_reset),
		.bad(bad), .core_cycle_valid(core_cycle_valid), .core_frame(core_frame),
		.core_call_taken(core_call_taken), .core_return_taken(core_return_taken),
		.core_invalid_access(core_invalid_access), .pa(pa)
	);
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Expected low word of a frame, from the program address it was made at
	function automatic logic [31:0] lo(input logic [15:0] p);
		return {p[11:2], ~p[7:0], 2'b10, p[3:0], p[7:0]};
	endfunction
	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
		if (n >= 20)
		begin
			chk("pready", 32'h0, 32'h1);
			end_of_test();
		end
	endtask
	// Bounded wait: for the core to stop, or for the counter to reach t
	task automatic wt(input logic stop, input logic [15:0] t);
		int n;
		n = 0;
		while ((stop ? core_run !== 1'b0 : pa < t) && n < 4000)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 4000)
		begin
			chk("wait", 32'h0, 32'h1);
			end_of_test();
		end
	endtask
	task automatic rd_status();
		apb(1'b0, OFS_STATUS, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Free run: the event ends tracing only, frames kept around the trigger
	task automatic t_free();
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, 8'h50, 32'h0003_0020);
		apb(1'b1, OFS_SELECT, 32'h10);
		apb(1'b1, OFS_DELAY, 32'h4);
		apb(1'b1, OFS_CMD, 32'h1);
		wt(1'b0, 16'h0060);
		chk("run_free", {31'h0, core_run}, 32'h1);
		rd_status();
		chk("trc_stat", rdat & 32'hc0, 32'h80);
		apb(1'b1, OFS_CMD, 32'h2);
		wt(1'b1, 16'h0);
		rd_status();
		chk("cause_halt", rdat & 32'h700, 32'h100);
		apb(1'b0, OFS_RDDATA, 32'h0);
		chk("trig_frame", rdat, lo(16'h0020));
		apb(1'b0, OFS_TRIG, 32'h0);
		apb(1'b1, OFS_RDPTR, rdat + 32'h4);
		apb(1'b0, OFS_RDDATA, 32'h0);
		chk("last_frame", rdat, lo(16'h0024));
	endtask
	// Break mode: the core stops the delay after the event, then single step
	task automatic t_brk(input logic [31:0] dly, input logic [15:0] d);
		base = pa + 16'h0040;
		apb(1'b1, OFS_CTRL, 32'h1);
		apb(1'b1, 8'h54, {16'h0003, base});
		apb(1'b1, OFS_SELECT, 32'h20);
		apb(1'b1, OFS_DELAY, dly);
		apb(1'b1, OFS_CMD, 32'h1);
		wt(1'b1, 16'h0);
		chk("in_step", {31'h0, core_in_step}, 32'h1);
		chk("late", {31'h0, (pa - base - d) inside {[1:4]}}, 32'h1);
		rd_status();
		chk("cause_evt", rdat & 32'h700, 32'h400);
		apb(1'b0, OFS_RDDATA, 32'h0);
		chk("trig_frame", rdat, lo(base));
	endtask
	// One step runs one instruction and leaves only its frame, escape leaves
	task automatic t_step();
		base = pa;
		apb(1'b1, OFS_CMD, 32'h8);
		wt(1'b0, base + 16'h1);
		wt(1'b1, 16'h0);
		chk("one_step", {16'h0, pa}, {16'h0, base + 16'h1});
		apb(1'b1, OFS_RDPTR, 32'h0);
		apb(1'b0, OFS_RDDATA, 32'h0);
		chk("step_frame", rdat, lo(base));
	endtask
	// Invalid access ends the program in free and break modes alike
	task automatic t_fail();
		for (int m = 0; m < 2; m++)
		begin
			apb(1'b1, OFS_CTRL, 32'(m));
			apb(1'b1, OFS_SELECT, 32'h0);
			apb(1'b1, OFS_CMD, 32'h1);
			wt(1'b0, pa + 16'h8);
			bad <= 1'b1;
			wt(1'b1, 16'h0);
			bad <= 1'b0;
			rd_status();
			chk("cause_bad", rdat & 32'h700, 32'h300);
		end
	endtask
	// Qualified then sectional trace: only frames at 0x20 and 0x30, or the span between
	task automatic t_qual();
		for (int m = 1; m < 3; m++)
		begin
			apb(1'b1, OFS_CMD, 32'h4);
			apb(1'b1, OFS_TMODE, 32'(m));
			apb(1'b1, OFS_SECTION, 32'h2010);
			apb(1'b1, 8'h54, 32'h30);
			apb(1'b1, OFS_CMD, 32'h1);
			wt(1'b0, 16'h0040);
			apb(1'b1, OFS_CMD, 32'h2);
			wt(1'b1, 16'h0);
			apb(1'b0, OFS_RDDATA, 32'h0);
			chk("first_rec", rdat, lo(16'h0020));
			apb(1'b1, OFS_RDPTR, (m == 1) ? 32'h1 : 32'h10);
			apb(1'b0, OFS_RDDATA, 32'h0);
			chk("last_rec", rdat, lo(16'h0030));
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		srst = 1'b1;
		{psel, penable, pwrite, bad} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		apb(1'b0, OFS_SELECT, 32'h0);
		chk("select", rdat & 32'h3f, 32'h30);
		apb(1'b0, 8'hfc, 32'h0);
		chk("slverr", {31'h0, rerr}, 32'h1);
		t_free();
		// Reset-halt clears the core counter while stopping it
		apb(1'b1, OFS_CMD, 32'h1);
		apb(1'b1, OFS_CMD, 32'h4);
		wt(1'b1, 16'h0);
		chk("pa_reset", {16'h0, pa}, 32'h0);
		rd_status();
		chk("cause_rst", rdat & 32'h700, 32'h200);
		t_brk(32'h2, 16'h0002);
		t_step();
		apb(1'b1, OFS_CMD, 32'h20);
		@(posedge sys_clk);
		chk("escaped", {31'h0, core_in_step}, 32'h0);
		t_brk(32'h0001_0000, 16'h03ff);
		apb(1'b1, OFS_CMD, 32'h20);
		t_fail();
		// Long unconditional run must wrap the circular memory
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_CMD, 32'h1);
		wt(1'b0, pa + 16'h0834);
		apb(1'b1, OFS_CMD, 32'h2);
		wt(1'b1, 16'h0);
		rd_status();
		chk("wrapped", rdat & 32'h20, 32'h20);
		t_qual();
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
